// File: src/dcc_pkg.sv
// Package for the two-channel converter control block: register map,
// field layouts, reset values and timing constants.
// Assumes a 200 MHz system clock and a plain word-addressed register port.
package dcc_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int CODE_W = 10;
  localparam int NUM_SRC = 4;

  localparam logic [ADDR_W-1:0] CHAN_A_CONTROL      = 6'h08;
  localparam logic [ADDR_W-1:0] CHAN_B_CONTROL      = 6'h0C;
  localparam logic [ADDR_W-1:0] CHAN_A_INPUT_CODE   = 6'h10;
  localparam logic [ADDR_W-1:0] CHAN_B_INPUT_CODE   = 6'h14;
  localparam logic [ADDR_W-1:0] MASKED_IRQ_STATUS   = 6'h18;
  localparam logic [ADDR_W-1:0] IRQ_MASK            = 6'h1C;
  localparam logic [ADDR_W-1:0] UNMASKED_IRQ_STATUS = 6'h20;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR           = 6'h24;

  // Field positions
  localparam int CTRL_LO = 0;
  localparam int CTRL_HI = 8;
  localparam int A_WAVE_LO = 16;
  localparam int A_WAVE_HI = 17;
  localparam int B_WAVE_LO = 9;
  localparam int B_WAVE_HI = 10;
  localparam int B_RSV_LO = 11;
  localparam int B_RSV_HI = 12;
  localparam int IRQ_W = 5;

  // Event flag bits
  localparam int IRQ_A_RDY = 0;
  localparam int IRQ_B_RDY = 1;
  localparam int IRQ_A_TMO = 2;
  localparam int IRQ_B_TMO = 3;
  localparam int IRQ_OVFL = 4;

  // Codes
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_BOTH = 2'h3;
  localparam logic [1:0] A_WAVE_TRI = 2'h1;
  localparam logic [1:0] B_WAVE_DIFF = 2'h3;

  // Reset values
  localparam logic [1:0] TRIG_TYP_RST = 2'h1;
  localparam logic [1:0] TRIG_SEL_RST = 2'h3;
  localparam logic [1:0] B_RSV_RST = 2'h3;
  localparam logic [IRQ_W-1:0] MASK_RST = 5'h1F;
  localparam logic [CODE_W-1:0] CODE_MAX = 10'h3FF;

  // Timing
  localparam int CLK_MHZ = 200;
  localparam int CONV_TIME_NS = 2000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMEOUT_US = 100;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
  localparam int TRI_AMP = 1023;

  typedef struct packed {
    logic       time_mode;
    logic       dma_en;
    logic [1:0] trig_typ;
    logic [1:0] trig_sel;
    logic       trig_en;
    logic       io_en;
    logic       en;
  } dcc_chan_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } dcc_bus_req_t;

endpackage

// File: src/dcc_top.sv
// Two-channel converter control: registers, triggering, conversion timing,
// event flags, DMA request and pad routing.
// Assumes synchronous inputs and a register master that never waits.
// How it works
// - External edge starts conversion only when trigger enabled
// - Pad carries result only when pad enable set
// - Channel converts only while its enable is set
// - Channel B wave 3 is differential with A
// - Channel B mode bit selects timing-related operation
// - Channel B DMA only while DMA enable set
// - Trigger type: rising, falling or both edges
// - Channel B code from 10-bit data field
// - Channel A data is code or triangle base
// - Triangle overflow sets read-only status bit 4
// - Masked status bits 0,1 show data ready
// - Masked status bits 2,3 show timeouts
// - Mask bit 4 blocks overflow; masks reset set
// - Mask bits 0-3 block ready and timeout events
// - Raw status shows flags regardless of mask
// - Writing 1 to clear bit clears flag
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dcc_top #(
  parameter int CONV_CYCLES    = dcc_pkg::CONV_CYCLES,
  parameter int TIMEOUT_CYCLES = dcc_pkg::TIMEOUT_CYCLES,
  parameter int TRI_AMP        = dcc_pkg::TRI_AMP
) (
  input  wire logic                                   sys_clk,
  input  wire logic                                   reset_n,
  input  wire dcc_pkg::dcc_bus_req_t                  bus_req,
  output var  logic [dcc_pkg::DATA_W-1:0]             rdata,
  input  wire logic [dcc_pkg::NUM_SRC-1:0]            evt_src,
  input  wire logic [1:0]                             dma_ack,
  input  wire logic [1:0][dcc_pkg::CODE_W-1:0]        dma_data,
  output var  logic [1:0]                             dma_req,
  output var  logic [1:0][dcc_pkg::CODE_W-1:0]        conv_code,
  output var  logic [1:0][dcc_pkg::CODE_W-1:0]        pad_code,
  output var  logic [1:0]                             pad_en
);

  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int W = dcc_pkg::CODE_W;

  typedef struct packed {
    dcc_pkg::dcc_chan_ctrl_t [1:0]  chan;
    logic [1:0]                     a_wave;
    logic [1:0]                     b_wave;
    logic [1:0]                     b_rsv;
    logic [1:0][W-1:0]              data;
    logic [dcc_pkg::IRQ_W-1:0]      irq_raw;
    logic [dcc_pkg::IRQ_W-1:0]      mask;
    logic [dcc_pkg::NUM_SRC-1:0]    src_prev;
    logic [1:0]                     busy;
    logic [1:0][CW-1:0]             conv_cnt;
    logic [1:0][TW-1:0]             tmo_cnt;
    logic [W-1:0]                   tri_pos;
    logic                           tri_down;
    logic [1:0][W-1:0]              out_code;
    logic [1:0][W-1:0]              pad_code;
    logic [1:0]                     pad_en;
    logic [1:0]                     dma_req;
    logic [dcc_pkg::DATA_W-1:0]     rdata;
  } dcc_state_t;

  dcc_state_t                  st;
  dcc_state_t                  next_st;
  logic [1:0]                  edge_hit;
  logic [1:0]                  start;
  logic [1:0]                  done;
  logic [1:0]                  data_wr;
  logic [dcc_pkg::IRQ_W-1:0]   irq_set;
  logic [dcc_pkg::IRQ_W-1:0]   irq_clr;
  logic [W:0]                  tri_sum;
  logic [W-1:0]                code_a;
  logic [1:0][W-1:0]           code_in;
  logic                        sel_cur;
  logic                        sel_old;

  assign rdata = st.rdata;
  assign dma_req = st.dma_req;
  assign conv_code = st.out_code;
  assign pad_code = st.pad_code;
  assign pad_en = st.pad_en;

  always_comb begin
    next_st = st;
    irq_set = '0;
    irq_clr = '0;
    edge_hit = '0;
    start = '0;
    done = '0;
    data_wr = '0;
    sel_cur = 1'b0;
    sel_old = 1'b0;
    next_st.src_prev = evt_src;
    next_st.rdata = '0;

    // Register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        dcc_pkg::CHAN_A_CONTROL: begin
          next_st.chan[0] = bus_req.wdata[dcc_pkg::CTRL_HI:dcc_pkg::CTRL_LO];
          next_st.a_wave = bus_req.wdata[dcc_pkg::A_WAVE_HI:dcc_pkg::A_WAVE_LO];
        end
        dcc_pkg::CHAN_B_CONTROL: begin
          next_st.chan[1] = bus_req.wdata[dcc_pkg::CTRL_HI:dcc_pkg::CTRL_LO];
          next_st.b_wave = bus_req.wdata[dcc_pkg::B_WAVE_HI:dcc_pkg::B_WAVE_LO];
          next_st.b_rsv = bus_req.wdata[dcc_pkg::B_RSV_HI:dcc_pkg::B_RSV_LO];
        end
        dcc_pkg::CHAN_A_INPUT_CODE: begin
          next_st.data[0] = bus_req.wdata[W-1:0];
          data_wr[0] = 1'b1;
        end
        dcc_pkg::CHAN_B_INPUT_CODE: begin
          next_st.data[1] = bus_req.wdata[W-1:0];
          data_wr[1] = 1'b1;
        end
        dcc_pkg::IRQ_MASK: begin
          next_st.mask = bus_req.wdata[dcc_pkg::IRQ_W-1:0];
        end
        dcc_pkg::IRQ_CLEAR: begin
          irq_clr = bus_req.wdata[dcc_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads, answered one cycle later
    if (bus_req.rd) begin
      case (bus_req.addr)
        dcc_pkg::CHAN_A_CONTROL: begin
          next_st.rdata[dcc_pkg::CTRL_HI:dcc_pkg::CTRL_LO] = st.chan[0];
          next_st.rdata[dcc_pkg::A_WAVE_HI:dcc_pkg::A_WAVE_LO] = st.a_wave;
        end
        dcc_pkg::CHAN_B_CONTROL: begin
          next_st.rdata[dcc_pkg::CTRL_HI:dcc_pkg::CTRL_LO] = st.chan[1];
          next_st.rdata[dcc_pkg::B_WAVE_HI:dcc_pkg::B_WAVE_LO] = st.b_wave;
          next_st.rdata[dcc_pkg::B_RSV_HI:dcc_pkg::B_RSV_LO] = st.b_rsv;
        end
        dcc_pkg::CHAN_A_INPUT_CODE: next_st.rdata[W-1:0] = st.data[0];
        dcc_pkg::CHAN_B_INPUT_CODE: next_st.rdata[W-1:0] = st.data[1];
        dcc_pkg::MASKED_IRQ_STATUS: next_st.rdata[dcc_pkg::IRQ_W-1:0] = st.irq_raw & ~st.mask;
        dcc_pkg::IRQ_MASK: next_st.rdata[dcc_pkg::IRQ_W-1:0] = st.mask;
        dcc_pkg::UNMASKED_IRQ_STATUS: next_st.rdata[dcc_pkg::IRQ_W-1:0] = st.irq_raw;
        default: next_st.rdata = '0;
      endcase
    end

    // Triangle code on channel A, base from the data field
    tri_sum = {1'b0, st.data[0]} + {1'b0, st.tri_pos};
    code_a = (st.a_wave == dcc_pkg::A_WAVE_TRI) ? tri_sum[W-1:0] : st.data[0];
    code_in[0] = code_a;
    code_in[1] = (st.b_wave == dcc_pkg::B_WAVE_DIFF) ? ~code_a : st.data[1];

    for (int i = 0; i < 2; i++) begin
      // DMA load of a fresh code
      if (st.dma_req[i] && dma_ack[i]) begin
        next_st.data[i] = dma_data[i];
        data_wr[i] = 1'b1;
      end
      sel_cur = evt_src[st.chan[i].trig_sel];
      sel_old = st.src_prev[st.chan[i].trig_sel];
      case (st.chan[i].trig_typ)
        dcc_pkg::TRIG_RISE: edge_hit[i] = sel_cur && !sel_old;
        dcc_pkg::TRIG_FALL: edge_hit[i] = !sel_cur && sel_old;
        dcc_pkg::TRIG_BOTH: edge_hit[i] = sel_cur != sel_old;
        default: edge_hit[i] = 1'b0;
      endcase
      start[i] = st.chan[i].en && !st.busy[i] &&
                 (st.chan[i].trig_en ? edge_hit[i] : data_wr[i]);
      done[i] = st.busy[i] && (st.conv_cnt[i] == CW'(CONV_CYCLES - 1));
      if (!st.chan[i].en) begin
        next_st.busy[i] = 1'b0;
        next_st.conv_cnt[i] = '0;
        next_st.tmo_cnt[i] = '0;
      end else if (start[i]) begin
        next_st.busy[i] = 1'b1;
        next_st.conv_cnt[i] = '0;
        next_st.tmo_cnt[i] = '0;
      end else if (done[i]) begin
        next_st.busy[i] = 1'b0;
        next_st.out_code[i] = code_in[i];
        irq_set[dcc_pkg::IRQ_A_RDY + i] = 1'b1;
      end else if (st.busy[i]) begin
        next_st.conv_cnt[i] = st.conv_cnt[i] + CW'(1);
      end else if (st.chan[i].time_mode) begin
        // Idle too long in timing-related mode
        if (st.tmo_cnt[i] == TW'(TIMEOUT_CYCLES - 1)) begin
          next_st.tmo_cnt[i] = '0;
          irq_set[dcc_pkg::IRQ_A_TMO + i] = 1'b1;
        end else begin
          next_st.tmo_cnt[i] = st.tmo_cnt[i] + TW'(1);
        end
      end
      // DMA request asked after a conversion, dropped on acknowledge
      if (done[i] && st.chan[i].en && st.chan[i].dma_en) begin
        next_st.dma_req[i] = 1'b1;
      end else if (dma_ack[i] || !st.chan[i].dma_en) begin
        next_st.dma_req[i] = 1'b0;
      end
      next_st.pad_en[i] = st.chan[i].en && st.chan[i].io_en;
      next_st.pad_code[i] = st.chan[i].io_en ? next_st.out_code[i] : '0;
    end

    // Triangle walk and overflow check per conversion
    if (done[0] && st.a_wave == dcc_pkg::A_WAVE_TRI) begin
      if ({1'b0, st.data[0]} + (W+1)'(TRI_AMP) > {1'b0, dcc_pkg::CODE_MAX}) begin
        irq_set[dcc_pkg::IRQ_OVFL] = 1'b1;
      end
      if (st.tri_down) begin
        next_st.tri_pos = st.tri_pos - W'(1);
        next_st.tri_down = st.tri_pos != W'(1);
      end else begin
        next_st.tri_pos = st.tri_pos + W'(1);
        next_st.tri_down = st.tri_pos == W'(TRI_AMP - 1);
      end
    end else if (st.a_wave != dcc_pkg::A_WAVE_TRI) begin
      next_st.tri_pos = '0;
      next_st.tri_down = 1'b0;
    end

    // Set wins over clear
    next_st.irq_raw = (st.irq_raw & ~irq_clr) | irq_set;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.chan[0].trig_typ <= dcc_pkg::TRIG_TYP_RST;
      st.chan[1].trig_typ <= dcc_pkg::TRIG_TYP_RST;
      st.chan[0].trig_sel <= dcc_pkg::TRIG_SEL_RST;
      st.chan[1].trig_sel <= dcc_pkg::TRIG_SEL_RST;
      st.b_rsv <= dcc_pkg::B_RSV_RST;
      st.mask <= dcc_pkg::MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  default clocking dcc_cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // Trigger gating and edge selection
  a_trig_gate: assert property (
    st.chan[0].en && !st.chan[0].trig_en && !st.busy[0] && !data_wr[0] |=> !st.busy[0])
    else $error("channel A started without cause");
  a_b_trig_gate: assert property (
    st.chan[1].en && !st.chan[1].trig_en && !st.busy[1] && !data_wr[1] |=> !st.busy[1])
    else $error("channel B started without cause");
  a_edge_start: assert property (
    st.chan[0].en && st.chan[0].trig_en && !st.busy[0] && edge_hit[0] |=> st.busy[0])
    else $error("channel A missed its trigger");
  a_rise_start: assert property (
    st.chan[0].en && st.chan[0].trig_en && !st.busy[0] && st.chan[0].trig_typ == dcc_pkg::TRIG_RISE
    && evt_src[st.chan[0].trig_sel] && !st.src_prev[st.chan[0].trig_sel] |=> st.busy[0])
    else $error("rising edge did not start");
  a_fall_start: assert property (
    st.chan[0].en && st.chan[0].trig_en && !st.busy[0] && st.chan[0].trig_typ == dcc_pkg::TRIG_FALL
    && !evt_src[st.chan[0].trig_sel] && st.src_prev[st.chan[0].trig_sel] |=> st.busy[0])
    else $error("falling edge did not start");
  a_fall_no_rise: assert property (
    st.chan[0].en && st.chan[0].trig_en && !st.busy[0] && st.chan[0].trig_typ == dcc_pkg::TRIG_FALL
    && evt_src[st.chan[0].trig_sel] && !st.src_prev[st.chan[0].trig_sel] |=> !st.busy[0])
    else $error("rising edge started falling mode");

  // Channel enable and pad routing
  a_disabled_idle: assert property (
    !st.chan[0].en |=> !st.busy[0] ##0 $stable(st.out_code[0]))
    else $error("disabled channel A converted");
  a_b_disabled_idle: assert property (
    !st.chan[1].en |=> !st.busy[1] ##0 $stable(st.out_code[1]))
    else $error("disabled channel B converted");
  a_pad_route: assert property (
    ##1 st.pad_en[1] == $past(st.chan[1].en && st.chan[1].io_en))
    else $error("pad enable wrong");
  a_a_pad_off: assert property (
    !st.chan[0].io_en |=> !st.pad_en[0] && st.pad_code[0] == '0)
    else $error("channel A pad driven while off");
  a_b_pad_off: assert property (
    !st.chan[1].io_en |=> !st.pad_en[1] && st.pad_code[1] == '0)
    else $error("channel B pad driven while off");

  // DMA handshake
  a_dma_gate: assert property (
    $rose(st.dma_req[1]) |-> $past(st.chan[1].dma_en && done[1]))
    else $error("DMA request without enable");
  a_dma_drop: assert property (
    st.dma_req[1] && dma_ack[1] && !done[1] |=> !st.dma_req[1])
    else $error("DMA request kept after acknowledge");

  // Conversion codes
  a_diff_code: assert property (
    done[1] && st.chan[1].en && st.b_wave == dcc_pkg::B_WAVE_DIFF |=> st.out_code[1] == ~$past(code_a))
    else $error("differential code wrong");
  a_b_data_start: assert property (
    st.chan[1].en && !st.chan[1].trig_en && !st.busy[1] && bus_req.wr
    && bus_req.addr == dcc_pkg::CHAN_B_INPUT_CODE |=> st.busy[1])
    else $error("channel B data write did not start");
  a_b_code_load: assert property (
    done[1] && st.chan[1].en && st.b_wave != dcc_pkg::B_WAVE_DIFF |=> st.out_code[1] == $past(st.data[1]))
    else $error("channel B code wrong");
  a_a_code_load: assert property (
    done[0] && st.chan[0].en && st.a_wave != dcc_pkg::A_WAVE_TRI |=> st.out_code[0] == $past(st.data[0]))
    else $error("channel A code wrong");
  a_tri_base: assert property (
    done[0] && st.chan[0].en && st.a_wave == dcc_pkg::A_WAVE_TRI
    |=> st.out_code[0] == W'($past(st.data[0]) + $past(st.tri_pos)))
    else $error("triangle code off its base");

  // Status reads, clear and mask
  a_masked_read: assert property (
    bus_req.rd && bus_req.addr == dcc_pkg::MASKED_IRQ_STATUS
    |=> rdata[4:0] == $past(st.irq_raw & ~st.mask) && rdata[31:5] == '0)
    else $error("masked status wrong");
  a_b_tmo_read: assert property (
    bus_req.rd && bus_req.addr == dcc_pkg::MASKED_IRQ_STATUS |=> rdata[dcc_pkg::IRQ_B_TMO]
    == $past(st.irq_raw[dcc_pkg::IRQ_B_TMO] && !st.mask[dcc_pkg::IRQ_B_TMO]))
    else $error("masked timeout wrong");
  a_raw_read: assert property (
    bus_req.rd && bus_req.addr == dcc_pkg::UNMASKED_IRQ_STATUS |=> rdata[4:0] == $past(st.irq_raw))
    else $error("raw status wrong");
  a_clear_flag: assert property (
    bus_req.wr && bus_req.addr == dcc_pkg::IRQ_CLEAR && bus_req.wdata[0]
    && !done[0] |=> !st.irq_raw[0])
    else $error("clear did not clear");
  a_mask_write: assert property (
    bus_req.wr && bus_req.addr == dcc_pkg::IRQ_MASK |=> st.mask == $past(bus_req.wdata[dcc_pkg::IRQ_W-1:0]))
    else $error("mask write lost");

  // Event flags
  a_ready_set: assert property (
    done[0] && st.chan[0].en |=> st.irq_raw[dcc_pkg::IRQ_A_RDY] && !st.busy[0])
    else $error("channel A ready flag not set");
  a_b_ready_set: assert property (
    done[1] && st.chan[1].en |=> st.irq_raw[dcc_pkg::IRQ_B_RDY] && !st.busy[1])
    else $error("channel B ready flag not set");
  a_ovfl_cause: assert property (
    $rose(st.irq_raw[dcc_pkg::IRQ_OVFL]) |-> $past(done[0] && st.a_wave == dcc_pkg::A_WAVE_TRI))
    else $error("overflow flag without triangle conversion");
  a_ovfl_hold: assert property (
    st.irq_raw[4] && !(bus_req.wr && bus_req.addr == dcc_pkg::IRQ_CLEAR)
    |=> st.irq_raw[4])
    else $error("overflow flag lost");
  a_a_tmo_cause: assert property (
    $rose(st.irq_raw[dcc_pkg::IRQ_A_TMO]) |-> $past(st.chan[0].en && st.chan[0].time_mode && !st.busy[0]))
    else $error("channel A timeout outside timing mode");
  a_b_tmo_cause: assert property (
    $rose(st.irq_raw[dcc_pkg::IRQ_B_TMO]) |-> $past(st.chan[1].en && st.chan[1].time_mode && !st.busy[1]))
    else $error("channel B timeout outside timing mode");

endmodule
`default_nettype wire

// File: bench/test_dcc_top.sv
// Self-checking bench for the two-channel converter control block.
// Assumes dcc_top with shortened counts and a register port answering next cycle.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_dcc_top;
  localparam int CONV = 4;
  localparam int TMO  = 20;
  localparam int DONE = CONV + 3;
  logic                                     sys_clk;
  logic                                     reset_n;
  dcc_pkg::dcc_bus_req_t                    bus_req;
  logic [dcc_pkg::DATA_W-1:0]               rdata;
  logic [dcc_pkg::NUM_SRC-1:0]              evt_src;
  logic [1:0]                               dma_ack;
  logic [1:0][dcc_pkg::CODE_W-1:0]          dma_data;
  logic [1:0]                               dma_req;
  logic [1:0][dcc_pkg::CODE_W-1:0]          conv_code;
  logic [1:0][dcc_pkg::CODE_W-1:0]          pad_code;
  logic [1:0]                               pad_en;
  logic [dcc_pkg::DATA_W-1:0]               rv;
  int                                       mismatches;
  int                                       cmp_count;
  int                                       cycles;

  dcc_top #(.CONV_CYCLES(CONV), .TIMEOUT_CYCLES(TMO), .TRI_AMP(7)) dut (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .bus_req  (bus_req),
    .rdata    (rdata),
    .evt_src  (evt_src),
    .dma_ack  (dma_ack),
    .dma_data (dma_data),
    .dma_req  (dma_req),
    .conv_code(conv_code),
    .pad_code (pad_code),
    .pad_en   (pad_en)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input logic [5:0] a, input logic [31:0] e);
    rd(a, rv);
    `CHK(rv, e)
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("Counts: %0d mismatches, %0d comparisons", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    reset_n = 1'b0;
    bus_req = '0;
    evt_src = '0;
    dma_ack = '0;
    dma_data = '0;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Reset values and unmapped read
    chk(6'h08, 32'h38);
    chk(6'h0C, 32'h1838);
    chk(6'h1C, 32'h1F);
    chk(6'h14, 32'h0);
    chk(6'h20, 32'h0);
    chk(6'h3C, 32'h0);
    `CHK(pad_en, 2'h0)
    // Disabled channel ignores data writes
    wr(6'h10, 32'h155);
    wt(DONE);
    chk(6'h20, 32'h0);
    `CHK(conv_code[0], 10'h0)
    // Channel A converts and drives pad, masked then unmasked
    wr(6'h08, 32'h3B);
    wr(6'h10, 32'h2AA);
    wt(DONE);
    `CHK(conv_code[0], 10'h2AA)
    `CHK(pad_code[0], 10'h2AA)
    `CHK(pad_en, 2'h1)
    `CHK(dma_req, 2'h0)
    chk(6'h20, 32'h1);
    chk(6'h18, 32'h0);
    wr(6'h1C, 32'h1E);
    chk(6'h1C, 32'h1E);
    chk(6'h18, 32'h1);
    wr(6'h24, 32'h1);
    chk(6'h20, 32'h0);
    // Channel B without pad routing
    wr(6'h0C, 32'h1839);
    wr(6'h14, 32'h3FF);
    wt(DONE);
    `CHK(conv_code[1], 10'h3FF)
    `CHK(pad_code[1], 10'h0)
    `CHK(pad_en, 2'h1)
    chk(6'h20, 32'h2);
    chk(6'h18, 32'h0);
    // Differential pairing
    wr(6'h0C, 32'h1E39);
    wr(6'h10, 32'h0F0);
    wr(6'h14, 32'h0);
    wt(DONE);
    `CHK(conv_code[0], 10'h0F0)
    `CHK(conv_code[1], 10'h30F)
    wr(6'h0C, 32'h1838);
    // Trigger types on source 2
    for (int t = 1; t <= 3; t++) begin
      wr(6'h08, 32'h15 | (t << 5));
      wr(6'h24, 32'h3);
      @(posedge sys_clk);
      evt_src[2] <= 1'b1;
      wt(DONE);
      chk(6'h20, {31'h0, t != 2});
      wr(6'h24, 32'h1);
      evt_src[2] <= 1'b0;
      wt(DONE);
      chk(6'h20, {31'h0, t != 1});
      wr(6'h24, 32'h1);
    end
    @(posedge sys_clk);
    evt_src[0] <= 1'b1;
    wt(DONE);
    chk(6'h20, 32'h0);
    wr(6'h08, 32'h71);
    evt_src[2] <= 1'b1;
    wt(DONE);
    chk(6'h20, 32'h0);
    // Triangle overflow
    wr(6'h08, 32'h10039);
    wr(6'h10, 32'h3FD);
    wt(DONE);
    rd(6'h20, rv);
    `CHK(rv[4], 1'b1)
    rd(6'h18, rv);
    `CHK(rv[4], 1'b0)
    wr(6'h1C, 32'h0F);
    rd(6'h18, rv);
    `CHK(rv[4], 1'b1)
    wr(6'h08, 32'h0);
    wr(6'h24, 32'h1F);
    wr(6'h18, 32'hFF);
    chk(6'h20, 32'h0);
    // DMA on channel B
    wr(6'h1C, 32'h1F);
    wr(6'h0C, 32'h18B9);
    wr(6'h14, 32'h011);
    wt(DONE);
    `CHK(dma_req, 2'h2)
    @(posedge sys_clk);
    dma_ack <= 2'h2;
    dma_data[1] <= 10'h222;
    @(posedge sys_clk);
    dma_ack <= 2'h0;
    #1;
    `CHK(dma_req, 2'h0)
    wt(DONE);
    `CHK(conv_code[1], 10'h222)
    wr(6'h0C, 32'h1839);
    wt(2);
    `CHK(dma_req, 2'h0)
    // Timeout in timing mode
    wr(6'h24, 32'h1F);
    wr(6'h08, 32'h139);
    wr(6'h0C, 32'h1939);
    wt(TMO + CONV + 5);
    rd(6'h20, rv);
    `CHK(rv[3], 1'b1)
    `CHK(rv[2], 1'b1)
    rd(6'h18, rv);
    `CHK(rv[3], 1'b0)
    wr(6'h1C, 32'h17);
    rd(6'h18, rv);
    `CHK(rv[3:2], 2'h2)
    print_verdict();
  end
endmodule
`default_nettype wire
